//--- first_wave_pkg.sv
// Purpose: Constants and types for the first-wave time-of-flight control block
// Assumes: Register words are 32 bits, time is counted in 25 ns system clocks
// Notes:   Register offsets, config field positions, the config reset value and the timeout base live here
// Overview of operation
// - Four-bit signed comparator trim, -8..+7 mV
// - First-wave builds on range two, analog path
// - Bit 30 enables first-wave, reinterprets masks
// - Five-bit signed trigger shift, 1 mV steps
// - Bit 13 adds minus twenty millivolts
// - Bit 14 adds plus twenty millivolts
// - At fire, apply shift; first mask active
// - After first half wave, offset back zero
// - Relative masks pick waves; ascending, first>=3
// - First measured hit half wave is reference
// - Bit 16 disables width; ratio at 8
// - Bit 15 picks rising or falling edge
// - Bit 31 enables hit sum at 4
// - All three hits computed without rewrite
// - No stop: offset held, timeout ends
// - Timeout interrupt selectable by bit 31
package first_wave_pkg;
  // Register addresses, write side
  localparam logic [3:0] ADDR_INT_CFG    = 4'h2;
  localparam logic [3:0] ADDR_MASK_CFG   = 4'h3;
  localparam logic [3:0] ADDR_LEVEL_CFG  = 4'h4;
  localparam logic [3:0] ADDR_TRIM_CFG   = 4'h6;
  // Register addresses, read side
  localparam logic [3:0] ADDR_HIT0       = 4'h0;
  localparam logic [3:0] ADDR_HIT1       = 4'h1;
  localparam logic [3:0] ADDR_HIT2       = 4'h2;
  localparam logic [3:0] ADDR_HIT_SUM    = 4'h4;
  localparam logic [3:0] ADDR_STATUS     = 4'h5;
  localparam logic [3:0] ADDR_RATIO      = 4'h8;
  localparam logic [31:0] REG_RESET      = 32'h0000_0000;
  // Field positions
  localparam int TRIM_LSB      = 25;  // comparator_trim, 4 bits, reg 6
  localparam int SHIFT_LSB     = 8;   // trigger_level_shift, 5 bits, reg 4
  localparam int MINUS20_BIT   = 13;
  localparam int PLUS20_BIT    = 14;
  localparam int EDGE_BIT      = 15;
  localparam int PW_DIS_BIT    = 16;
  localparam int FW_EN_BIT     = 30;  // reg 3
  localparam int AUTO_SUM_BIT  = 31;  // reg 3
  localparam int TIMO_SEL_LSB  = 27;  // range2_timeout_select, 2 bits, reg 3
  localparam int REL_A_LSB     = 8;   // rel_mask_wave_a..c, 6 bits each, reg 3
  localparam int REL_B_LSB     = 14;
  localparam int REL_C_LSB     = 20;
  localparam int ABS_LSB       = 8;   // abs_mask_a..c, 19 bits, regs 2..4
  localparam int ABS_FRAC      = 5;   // Fraction bits of an absolute mask
  localparam int ALU_INT_BIT   = 29;  // reg 2
  localparam int TIMO_INT_BIT  = 31;  // reg 2
  localparam int RATIO_FRAC    = 7;   // 1.7 fixed point ratio
  localparam logic signed [7:0] RANGE_SHIFT_MV = 8'sh14;
  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int TIMO_BASE_NS  = 64000;  // Shortest timeout, sel 0
  localparam int TIMO_BASE_CYC = TIMO_BASE_NS / CLK_PERIOD_NS;  // Rounds down
  // Measurement sequence states
  typedef enum logic [2:0] {ST_IDLE, ST_ARMED, ST_LEAD, ST_WAVES, ST_CALC} meas_state_t;
  // Decoded configuration
  typedef struct packed {
    logic              fw_en;
    logic              auto_sum;
    logic              pw_dis;
    logic              edge_fall;
    logic [1:0]        timo_sel;
    logic [5:0]        rel_a;
    logic [5:0]        rel_b;
    logic [5:0]        rel_c;
    logic [13:0]       abs_a;
    logic [13:0]       abs_b;
    logic [13:0]       abs_c;
    logic signed [7:0] trim_mv;
    logic signed [7:0] shift_mv;
  } fw_cfg_t;
endpackage : first_wave_pkg

//--- first_wave_tof_control.sv
// Purpose: First-wave detection, masking, pulse-width ratio and hit summing
// Assumes: comp_i is the receive comparator output, asynchronous to clk_sys_i
// Notes:   start_i marks the fire burst; times count in system clocks
`timescale 1ns/1ps
module first_wave_tof_control #(
  parameter int TIMER_W       = 20,                           // Wide enough for 4096 us
  parameter int TIMO_BASE_CYC = first_wave_pkg::TIMO_BASE_CYC // Shorten in simulation
) (
  input  wire logic              clk_sys_i,
  input  wire logic              rst_n_i,
  input  wire logic              wr_en_i,       // Config write strobe
  input  wire logic [3:0]        wr_addr_i,
  input  wire logic [31:0]       wr_data_i,
  input  wire logic [3:0]        rd_addr_i,
  output logic      [31:0]       rd_data_o,     // Registered read data
  input  wire logic              start_i,       // Fire pulses begin
  input  wire logic              comp_i,        // Comparator output pin
  output logic signed [7:0]      comp_offset_o, // Comparator threshold offset, mV
  output logic                   mask_open_o,   // Stops currently accepted
  output logic                   irq_o
);
  // Stored configuration words
  logic [31:0] int_cfg_q, mask_cfg_q, level_cfg_q, trim_cfg_q;
  logic [31:0] int_cfg_d, mask_cfg_d, level_cfg_d, trim_cfg_d;
  first_wave_pkg::fw_cfg_t cfg;
  // Comparator synchroniser and edge history
  logic comp_s1_q, comp_s2_q, comp_s3_q;
  logic edge_sel, edge_opp;
  // Measurement state
  first_wave_pkg::meas_state_t state_q, state_d;
  logic [TIMER_W-1:0]  timer_q, timer_d, timo_lim;
  logic [TIMER_W-1:0]  hit_q [3];
  logic [TIMER_W-1:0]  hit_d [3];
  logic [1:0]          nhit_q, nhit_d;       // Hits captured so far
  logic [5:0]          waves_q, waves_d;     // Waves after the lead edge
  logic [15:0]         lead_w_q, lead_w_d;   // First half-wave width
  logic [15:0]         ref_w_q, ref_w_d;     // Reference half-wave width
  logic                ref_run_q, ref_run_d;
  logic                trigger_level_shift_act_q, trigger_level_shift_act_d; // First-wave shift applied
  logic                timeout_q, timeout_d, done_q, done_d;
  logic [31:0]         sum_q, sum_d;
  logic [7:0]          ratio_q, ratio_d;
  logic signed [7:0]   offset_q, offset_d;
  logic [31:0]         rd_d;
  logic                take;                 // Current wave is a wanted hit
  logic [23:0]         ratio_raw;            // Width ratio before saturation

  // Trim is two's complement; the wide shift counts down from code 16 (-1 mV)
  function automatic logic signed [7:0] sext_mv(input logic [4:0] v, input logic wide);
    sext_mv = wide ? (v[4] ? {4'hF, ~v[3:0]} : {4'h0, v[3:0]}) : 8'(signed'(v[3:0]));
  endfunction : sext_mv

  // Absolute mask integer part in clocks
  function automatic logic [13:0] abs_int(input logic [31:0] w);
    abs_int = w[first_wave_pkg::ABS_LSB+first_wave_pkg::ABS_FRAC +: 14];
  endfunction : abs_int

  // Field decode; first-wave mode reuses the mask bits of regs 3 and 4
  always_comb begin
    cfg.fw_en     = mask_cfg_q[first_wave_pkg::FW_EN_BIT];
    cfg.auto_sum  = mask_cfg_q[first_wave_pkg::AUTO_SUM_BIT];
    cfg.pw_dis    = level_cfg_q[first_wave_pkg::PW_DIS_BIT];
    cfg.edge_fall = level_cfg_q[first_wave_pkg::EDGE_BIT];
    cfg.timo_sel  = mask_cfg_q[first_wave_pkg::TIMO_SEL_LSB +: 2];
    cfg.rel_a     = mask_cfg_q[first_wave_pkg::REL_A_LSB +: 6];
    cfg.rel_b     = mask_cfg_q[first_wave_pkg::REL_B_LSB +: 6];
    cfg.rel_c     = mask_cfg_q[first_wave_pkg::REL_C_LSB +: 6];
    cfg.abs_a     = abs_int(int_cfg_q);
    cfg.abs_b     = abs_int(mask_cfg_q);
    cfg.abs_c     = abs_int(level_cfg_q);
    cfg.trim_mv   = sext_mv({1'b0, trim_cfg_q[first_wave_pkg::TRIM_LSB +: 4]}, 1'b0);
    cfg.shift_mv  = sext_mv(level_cfg_q[first_wave_pkg::SHIFT_LSB +: 5], 1'b1);
  end

  // Edges of the synchronised comparator; polarity chosen by config
  assign edge_sel = cfg.edge_fall ? (comp_s3_q & ~comp_s2_q) : (~comp_s3_q & comp_s2_q);
  assign edge_opp = cfg.edge_fall ? (~comp_s3_q & comp_s2_q) : (comp_s3_q & ~comp_s2_q);
  // Timeout grows by four per select step
  assign timo_lim = TIMER_W'(TIMO_BASE_CYC) << {cfg.timo_sel, 1'b0};

  // Config register writes
  always_comb begin
    int_cfg_d   = int_cfg_q;
    mask_cfg_d  = mask_cfg_q;
    level_cfg_d = level_cfg_q;
    trim_cfg_d  = trim_cfg_q;
    if (wr_en_i) begin
      case (wr_addr_i)
        first_wave_pkg::ADDR_INT_CFG:   int_cfg_d   = wr_data_i;
        first_wave_pkg::ADDR_MASK_CFG:  mask_cfg_d  = wr_data_i;
        first_wave_pkg::ADDR_LEVEL_CFG: level_cfg_d = wr_data_i;
        first_wave_pkg::ADDR_TRIM_CFG:  trim_cfg_d  = wr_data_i;
        default: ;                       // Other addresses ignored
      endcase
    end
  end

  // Measurement sequencer next state
  always_comb begin
    state_d    = state_q;
    timer_d    = timer_q;
    hit_d      = hit_q;
    nhit_d     = nhit_q;
    waves_d    = waves_q;
    lead_w_d   = lead_w_q;
    ref_w_d    = ref_w_q;
    ref_run_d  = ref_run_q;
    trigger_level_shift_act_d = trigger_level_shift_act_q;
    timeout_d  = timeout_q;
    done_d     = done_q;
    sum_d      = sum_q;
    ratio_d    = ratio_q;
    take       = 1'b0;
    ratio_raw  = 24'h000000;
    // Reference half wave runs until the opposite edge
    if (ref_run_q) begin
      ref_w_d = ref_w_q + 16'h0001;
      if (edge_opp) ref_run_d = 1'b0;
    end
    if (state_q != first_wave_pkg::ST_IDLE && state_q != first_wave_pkg::ST_CALC) begin
      timer_d = timer_q + TIMER_W'(1);
      // No stop in time: end here and keep the shift applied
      if (timer_q >= timo_lim) begin
        timeout_d = 1'b1;
        ref_run_d = 1'b0;
        state_d   = first_wave_pkg::ST_IDLE;
      end
    end
    case (state_q)
      first_wave_pkg::ST_IDLE: begin
        if (start_i) begin
          timer_d    = '0;
          nhit_d     = 2'd0;
          waves_d    = 6'd0;
          lead_w_d   = 16'h0000;
          ref_w_d    = 16'h0000;
          hit_d      = '{default: '0};
          timeout_d  = 1'b0;
          done_d     = 1'b0;
          trigger_level_shift_act_d = cfg.fw_en;
          state_d    = first_wave_pkg::ST_ARMED;
        end
      end
      first_wave_pkg::ST_ARMED: begin
        // First absolute mask guards both modes
        if (timer_q < timo_lim && edge_sel && timer_q >= TIMER_W'(cfg.abs_a)) begin
          if (cfg.fw_en) begin
            state_d = first_wave_pkg::ST_LEAD;
          end else begin
            hit_d[0] = timer_q;
            nhit_d   = 2'd1;
            state_d  = first_wave_pkg::ST_WAVES;
          end
        end
      end
      first_wave_pkg::ST_LEAD: begin
        if (timer_q < timo_lim) begin
          lead_w_d = lead_w_q + 16'h0001;
          if (edge_opp) begin
            trigger_level_shift_act_d = 1'b0;
            state_d    = first_wave_pkg::ST_WAVES;
          end
        end
      end
      first_wave_pkg::ST_WAVES: begin
        if (timer_q < timo_lim && edge_sel) begin
          if (cfg.fw_en) begin
            // Waves counted from the lead edge pick the hits
            waves_d = waves_q + 6'd1;
            case (nhit_q)
              2'd0:    take = (waves_q + 6'd1 == cfg.rel_a);
              2'd1:    take = (waves_q + 6'd1 == cfg.rel_b);
              default: take = (waves_q + 6'd1 == cfg.rel_c);
            endcase
          end else begin
            case (nhit_q)
              2'd1:    take = (timer_q >= TIMER_W'(cfg.abs_b));
              default: take = (timer_q >= TIMER_W'(cfg.abs_c));
            endcase
          end
          if (take) begin
            hit_d[nhit_q] = timer_q;
            nhit_d        = nhit_q + 2'd1;
            if (nhit_q == 2'd0 && cfg.fw_en && !cfg.pw_dis) begin
              ref_run_d = 1'b1;
            end
            if (nhit_q == 2'd2) state_d = first_wave_pkg::ST_CALC;
          end
        end
      end
      first_wave_pkg::ST_CALC: begin
        // Wait for a reference still open, then finish
        if (!ref_run_q) begin
          sum_d = cfg.auto_sum ? 32'(hit_q[0]) + 32'(hit_q[1]) + 32'(hit_q[2]) : 32'h0;
          if (cfg.fw_en && !cfg.pw_dis && ref_w_q != 16'h0000) begin
            ratio_raw = {lead_w_q, 8'h00} / {8'h00, ref_w_q};
            ratio_d = (ratio_raw[23:1] > 23'h0000FF) ? 8'hFF : ratio_raw[8:1]; // Saturate at 1.99
          end else begin
            ratio_d = 8'h00;
          end
          done_d  = 1'b1;
          state_d = first_wave_pkg::ST_IDLE;
        end
      end
      default: state_d = first_wave_pkg::ST_IDLE;
    endcase
    // Threshold offset: trim plus first-wave shift while applied
    offset_d = cfg.trim_mv;
    if (trigger_level_shift_act_d) begin
      offset_d = offset_d + cfg.shift_mv;
      if (level_cfg_q[first_wave_pkg::MINUS20_BIT]) begin
        offset_d = offset_d - first_wave_pkg::RANGE_SHIFT_MV;
      end
      if (level_cfg_q[first_wave_pkg::PLUS20_BIT]) begin
        offset_d = offset_d + first_wave_pkg::RANGE_SHIFT_MV;
      end
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    case (rd_addr_i)
      first_wave_pkg::ADDR_HIT0:    rd_d = 32'(hit_q[0]);
      first_wave_pkg::ADDR_HIT1:    rd_d = 32'(hit_q[1]);
      first_wave_pkg::ADDR_HIT2:    rd_d = 32'(hit_q[2]);
      first_wave_pkg::ADDR_HIT_SUM: rd_d = sum_q;
      first_wave_pkg::ADDR_STATUS:  rd_d = {27'h0, nhit_q, trigger_level_shift_act_q, done_q, timeout_q};
      first_wave_pkg::ADDR_RATIO:   rd_d = {24'h0, ratio_q};
      default:                      rd_d = 32'h0000_0000;
    endcase
  end

  // All state registers
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      int_cfg_q   <= first_wave_pkg::REG_RESET;
      mask_cfg_q  <= first_wave_pkg::REG_RESET;
      level_cfg_q <= first_wave_pkg::REG_RESET;
      trim_cfg_q  <= first_wave_pkg::REG_RESET;
      comp_s1_q   <= 1'b0;
      comp_s2_q   <= 1'b0;
      comp_s3_q   <= 1'b0;
      state_q     <= first_wave_pkg::ST_IDLE;
      timer_q     <= '0;
      hit_q       <= '{default: '0};
      nhit_q      <= 2'd0;
      waves_q     <= 6'd0;
      lead_w_q    <= 16'h0000;
      ref_w_q     <= 16'h0000;
      ref_run_q   <= 1'b0;
      trigger_level_shift_act_q  <= 1'b0;
      timeout_q   <= 1'b0;
      done_q      <= 1'b0;
      sum_q       <= 32'h0000_0000;
      ratio_q     <= 8'h00;
      offset_q    <= 8'sh00;
      rd_data_o   <= 32'h0000_0000;
    end else begin
      int_cfg_q   <= int_cfg_d;
      mask_cfg_q  <= mask_cfg_d;
      level_cfg_q <= level_cfg_d;
      trim_cfg_q  <= trim_cfg_d;
      comp_s1_q   <= comp_i;
      comp_s2_q   <= comp_s1_q;
      comp_s3_q   <= comp_s2_q;
      state_q     <= state_d;
      timer_q     <= timer_d;
      hit_q       <= hit_d;
      nhit_q      <= nhit_d;
      waves_q     <= waves_d;
      lead_w_q    <= lead_w_d;
      ref_w_q     <= ref_w_d;
      ref_run_q   <= ref_run_d;
      trigger_level_shift_act_q  <= trigger_level_shift_act_d;
      timeout_q   <= timeout_d;
      done_q      <= done_d;
      sum_q       <= sum_d;
      ratio_q     <= ratio_d;
      offset_q    <= offset_d;
      rd_data_o   <= rd_d;
    end
  end

  assign comp_offset_o = offset_q;
  // Stops pass once the first absolute mask has expired
  assign mask_open_o = (state_q != first_wave_pkg::ST_IDLE) && (timer_q >= TIMER_W'(cfg.abs_a));
  // Sources combined by OR; held until the next start
  assign irq_o = (timeout_q & int_cfg_q[first_wave_pkg::TIMO_INT_BIT])
               | (done_q & int_cfg_q[first_wave_pkg::ALU_INT_BIT]);

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  property p_fire_shift;
    state_q == first_wave_pkg::ST_IDLE && start_i && cfg.fw_en |=> trigger_level_shift_act_q;
  endproperty
  a_fire_shift: assert property (p_fire_shift) else $error("shift not applied at fire");
  property p_back_to_zero;
    state_q == first_wave_pkg::ST_LEAD && edge_opp && timer_q < timo_lim
      |=> !trigger_level_shift_act_q ##1 offset_q == cfg.trim_mv;
  endproperty
  a_back_to_zero: assert property (p_back_to_zero) else $error("offset not returned");
  property p_plain_mode;
    !cfg.fw_en && state_q == first_wave_pkg::ST_IDLE && start_i |=> !trigger_level_shift_act_q;
  endproperty
  a_plain_mode: assert property (p_plain_mode) else $error("shift in plain mode");
  property p_minus20;
    trigger_level_shift_act_q && $stable(level_cfg_q) && level_cfg_q[14:13] == 2'b01 && $stable(trim_cfg_q)
      |-> offset_q == cfg.trim_mv + cfg.shift_mv - 8'sh14;
  endproperty
  a_minus20: assert property (p_minus20) else $error("minus range wrong");
  property p_plus20;
    trigger_level_shift_act_q && $stable(level_cfg_q) && level_cfg_q[14:13] == 2'b10 && $stable(trim_cfg_q)
      |-> offset_q == cfg.trim_mv + cfg.shift_mv + 8'sh14;
  endproperty
  a_plus20: assert property (p_plus20) else $error("plus range wrong");
  property p_timeout_hold;
    $rose(timeout_q) && $past(trigger_level_shift_act_q) |-> trigger_level_shift_act_q;
  endproperty
  a_timeout_hold: assert property (p_timeout_hold) else $error("offset dropped on timeout");
  property p_sum;
    $rose(done_q) && cfg.auto_sum && $stable(mask_cfg_q)
      |-> sum_q == 32'(hit_q[0]) + 32'(hit_q[1]) + 32'(hit_q[2]);
  endproperty
  a_sum: assert property (p_sum) else $error("hit sum wrong");
  property p_pw_off;
    $rose(done_q) && $past(cfg.pw_dis) |-> ratio_q == 8'h00 && !ref_run_q;
  endproperty
  a_pw_off: assert property (p_pw_off) else $error("ratio with width off");
  property p_timo_irq;
    state_q inside {first_wave_pkg::ST_ARMED, first_wave_pkg::ST_LEAD, first_wave_pkg::ST_WAVES}
      && timer_q >= timo_lim && int_cfg_q[first_wave_pkg::TIMO_INT_BIT] |=> irq_o;
  endproperty
  a_timo_irq: assert property (p_timo_irq) else $error("timeout irq missing");
  property p_three_hits;
    $rose(done_q) |-> nhit_q == 2'd3 && state_q == first_wave_pkg::ST_IDLE;
  endproperty
  a_three_hits: assert property (p_three_hits) else $error("done without three hits");
endmodule : first_wave_tof_control

//--- wave_source.sv
// Purpose: Receive comparator model, one noise spike then a wave burst
// Assumes: Bursts are armed by the fire pulse, one clock per count
// Notes:   Output rests low outside bursts, like an idle comparator
`timescale 1ns/1ps
module wave_source #(
  parameter int HALF     = 4,  // Half-wave length in clocks
  parameter int DELAY    = 30, // Fire to first wave
  parameter int NWAVES   = 12, // Waves in one burst
  parameter int NOISE_AT = 2   // Early spike the first mask must reject
) (
  input  wire logic clk_i,
  input  wire logic fire_i,
  input  wire logic waves_en_i,
  output logic      comp_o
);
  int   cnt = 0;     // Clocks since fire
  logic run = 1'b0;  // Burst in progress
  // Count from the fire pulse until the burst is over
  always @(posedge clk_i) begin
    if (fire_i) begin
      run <= 1'b1;
      cnt <= 0;
    end else if (run) begin
      cnt <= cnt + 1;
    end
    if (run && cnt > DELAY + 2 * HALF * NWAVES) run <= 1'b0;
  end
  // Spike always comes; waves only when enabled, so an empty tube times out
  always_comb begin
    comp_o = 1'b0;
    if (run && cnt == NOISE_AT) comp_o = 1'b1;
    if (run && waves_en_i && cnt >= DELAY && cnt < DELAY + 2 * HALF * NWAVES) begin
      comp_o = ((cnt - DELAY) / HALF) % 2 == 0;
    end
  end
endmodule : wave_source

//--- tb_top.sv
// Purpose: Self-checking bench for the first-wave control block
// Assumes: Timeout base shortened to 400 clocks, waves of 8 clocks
// Notes:   Hit checks use spacing and windows, not exact latency
`timescale 1ns/1ps
module tb_top;
  logic              clk_sys_i   = 1'b0;
  logic              rst_n_i     = 1'b0;
  logic              wr_en_i     = 1'b0;
  logic [3:0]        wr_addr_i   = 4'h0;
  logic [31:0]       wr_data_i   = 32'h0;
  logic [3:0]        rd_addr_i   = 4'h0;
  logic [31:0]       rd_data_o;
  logic              start_i     = 1'b0;
  logic              comp_i;
  logic signed [7:0] comp_offset_o;
  logic              mask_open_o;
  logic              irq_o;
  logic              waves_en    = 1'b0; // Burst on or empty tube
  int                miscompares = 0;
  int                n_checks    = 0;
  always #12.5 clk_sys_i = ~clk_sys_i;
  first_wave_tof_control #(.TIMO_BASE_CYC(400)) first_wave_tof_control_inst (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wr_en_i(wr_en_i),
    .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i), .rd_addr_i(rd_addr_i),
    .rd_data_o(rd_data_o), .start_i(start_i), .comp_i(comp_i),
    .comp_offset_o(comp_offset_o), .mask_open_o(mask_open_o), .irq_o(irq_o));
  wave_source wave_source_inst (
    .clk_i(clk_sys_i), .fire_i(start_i), .waves_en_i(waves_en), .comp_o(comp_i));
  // Every task starts and ends 2 ns after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #2;
  endtask : tick
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    wr_addr_i = a;
    wr_data_i = d;
    wr_en_i   = 1'b1;
    tick(1);
    // Strobe rests one cycle so a following write starts on a fresh edge
    wr_en_i   = 1'b0;
    tick(1);
  endtask : wr
  // Read data is registered, so it is valid after the sampling edge
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    rd_addr_i = a;
    tick(1);
    d = rd_data_o;
  endtask : rd
  task automatic fire;
    start_i = 1'b1;
    tick(1);
    start_i = 1'b0;
  endtask : fire
  // Poll one status bit, bounded so a hang ends the run
  task automatic wait_bit(input int b, output logic [31:0] s);
    for (int i = 0; i < 3000; i++) begin
      rd(4'h5, s);
      if (s[b] === 1'b1) return;
    end
    miscompares++;
    $display("CHECK FAILED at %0t: status wait expired", $time);
    final_report();
  endtask : wait_bit
  // Empty tube: shift applied at fire, held through the timeout
  task automatic run_offset(input logic [31:0] lvl, input logic signed [7:0] exp);
    logic [31:0] s;
    wr(4'h4, lvl);
    fire();
    tick(1);
    chk({24'h0, comp_offset_o}, {24'h0, exp}, "shift at fire");
    chk({31'h0, mask_open_o}, 32'h0, "mask early");
    tick(10);
    chk({31'h0, mask_open_o}, 32'h1, "mask open");
    wait_bit(0, s);
    chk({31'h0, irq_o}, 32'h1, "timeout irq");
    chk({24'h0, comp_offset_o}, {24'h0, exp}, "shift held");
    $display("offset run done");
  endtask : run_offset
  // Longer timeout select: still running past the shortest limit
  task automatic run_timo;
    logic [31:0] s;
    wr(4'h3, 32'hC851_0300);
    fire();
    tick(500);
    rd(4'h5, s);
    chk({31'h0, s[0]}, 32'h0, "timeout too early");
    wait_bit(0, s);
    chk({31'h0, irq_o}, 32'h1, "long timeout irq");
    wr(4'h3, 32'hC051_0300);
    $display("timeout select run done");
  endtask : run_timo
  // Burst run: hit spacing, window of hit 0, sum and ratio
  task automatic run_fw(input logic [31:0] lvl, input logic fw, input logic [31:0] ratio,
                        input int lo);
    logic [31:0] s;
    logic [31:0] h [3];
    wr(4'h4, lvl);
    waves_en = 1'b1;
    fire();
    wait_bit(1, s);
    chk({31'h0, irq_o}, 32'h1, "done irq");
    chk({24'h0, comp_offset_o}, 32'h0000_00FD, "offset back");
    for (int k = 0; k < 3; k++) rd(k[3:0], h[k]);
    chk(h[1] - h[0], 32'h8, "wave b spacing");
    chk(h[2] - h[1], 32'h8, "wave c spacing");
    chk({31'h0, h[0] >= lo && h[0] <= lo + 6}, 32'h1, "hit 0 window");
    rd(4'h4, s);
    chk(s, fw ? h[0] + h[1] + h[2] : 32'h0, "hit sum");
    if (fw) begin
      rd(4'h8, s);
      chk(s, ratio, "width ratio");
    end
    waves_en = 1'b0;
    $display("burst run done");
  endtask : run_fw
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  initial begin
    tick(12);
    rst_n_i = 1'b1;
    tick(1);
    wr(4'h2, 32'hA001_4000);
    wr(4'h3, 32'hC051_0300);
    wr(4'h6, 32'h1A00_0000);
    tick(1);
    chk({24'h0, comp_offset_o}, 32'h0000_00FD, "trim only");
    run_offset(32'h0000_0F00, 8'sh0C);
    run_offset(32'h0000_1000, 8'shFC);
    run_offset(32'h0000_3F00, 8'shD9);
    run_offset(32'h0000_4000, 8'sh11);
    run_timo();
    run_fw(32'h0000_0500, 1'b1, 32'h80, 54);
    run_fw(32'h0000_8500, 1'b1, 32'h80, 58);
    run_fw(32'h0001_0500, 1'b1, 32'h00, 54);
    wr(4'h3, 32'h0000_0000);
    run_fw(32'h0000_0500, 1'b0, 32'h00, 30);
    final_report();
  end
endmodule : tb_top
